// ### design/chan_cfg_map.svh
// Field positions, reset values and timing counts of the channel block.
// Assumes a single 40 MHz clock; included by its bare name.
`ifndef CHAN_CFG_MAP_SVH
`define CHAN_CFG_MAP_SVH

// ----------------------------------------
// Channel mode fields
// ----------------------------------------
`define MODE_RESET       8'h00
`define MODE_AUXA_BIT    0
`define MODE_AUXB_BIT    1
`define MODE_DIODE2_BIT  2
`define MODE_RANGE5_BIT  3
`define MODE_ALERT0_BIT  4
`define MODE_ALERT1_BIT  5
`define MODE_ALERT2_BIT  6
`define MODE_ALERTS_BIT  7

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS    25
`define CONV_PERIOD_NS   748000
`define DIODE_MEAS_NS    9600000
`define DIODE_AVG_COUNT  16
`define CONV_CYCLES      (`CONV_PERIOD_NS / `CLK_PERIOD_NS)
`define DIODE_SUB_CYCLES (`DIODE_MEAS_NS / `DIODE_AVG_COUNT / `CLK_PERIOD_NS)

`endif

// ### design/chan_cfg_pkg.sv
// Types shared by the measurement channel sequencer and its bench.
// Assumes the constants of chan_cfg_map.svh.
package chan_cfg_pkg;

  // ----------------------------------------
  // Channels in round-robin order
  // ----------------------------------------
  typedef enum logic [3:0] {
    CH_DIODE1 = 4'h0,
    CH_12V    = 4'h1,
    CH_5V     = 4'h2,
    CH_CORE_A = 4'h3,
    CH_VCC    = 4'h4,
    CH_AUXA   = 4'h5,
    CH_AUXB   = 4'h6,
    CH_2V5    = 4'h7,
    CH_CORE_B = 4'h8,
    CH_DIODE2 = 4'h9
  } chan_t;

  // ----------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_SELECT  = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_STORE   = 4'b1000
  } seq_state_t;

endpackage : chan_cfg_pkg

// ### design/period_tick.sv
// Slot timer: one-cycle tick a programmable number of cycles after restart.
// Assumes restart and period come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module period_tick #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // Control
  input  wire logic         restart,
  input  wire logic [W-1:0] period,
  // Event
  output logic              tick
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         busy_reg;
  logic         busy_next;

  always_comb begin
    tick      = busy_reg && (cnt_reg == period - W'(1));
    cnt_next  = cnt_reg + W'(1);
    busy_next = busy_reg && !tick;
    if (restart) begin
      cnt_next  = '0;
      busy_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end
endmodule : period_tick
`default_nettype wire

// ### design/diode_avg.sv
// Averager for remote-diode samples, two's complement in and out.
// Assumes clr precedes the first add of each measurement.
`timescale 1ns/1ps
`default_nettype none
module diode_avg #(
  parameter int LOG2N = 4
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // Samples
  input  wire logic              clr,
  input  wire logic              add,
  input  wire logic signed [7:0] sample,
  // Result
  output logic signed [7:0]      avg
);
  logic signed [7+LOG2N:0] acc_reg;
  logic signed [7+LOG2N:0] acc_next;

  always_comb begin
    acc_next = acc_reg;
    if (clr) begin
      acc_next = '0;
    end else if (add) begin
      acc_next = acc_reg + (8+LOG2N)'(sample);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // Truncating shift: rounds toward minus infinity
  assign avg = acc_reg[7+LOG2N:LOG2N];
endmodule : diode_avg
`default_nettype wire

// ### design/measurement_channel_config.sv
// Channel mode register and round-robin conversion sequencer of a hardware monitor.
// Assumes the SAR converter, analog mux and value registers sit outside on sys_clk.
//
// Functional notes
// [RQ1] Mode bits 0,1: tach or analog pin
// [RQ2] Mode bit 2: rails or second diode
// [RQ3] Mode bit 3: internal supply 3.3/5 V range
// [RQ4] Mode bit 7: code pins become alert inputs
// [RQ5] Mode bits 4-6 enable alerts 0-2
// [RQ6] Config2 bits 6,7 enable alerts 3,4
// [RQ7] Mode register resets to zero
// [RQ8] Dedicated channels ignore the mode register
// [RQ9] One shared 8-bit converter for all inputs
// [RQ10] Attenuated rails: nominal gives code 192
// [RQ11] One ordinary conversion every 748 us
// [RQ12] Diode result averages sixteen conversions, 9.6 ms
// [RQ13] Each enabled input measured, result stored
// [RQ14] Sequence repeats until start bit cleared
// [RQ15] Diode results stored two's complement
// [RQ16] Skip tach pins; bit 2 means diode
`timescale 1ns/1ps
`default_nettype none
`include "chan_cfg_map.svh"
module measurement_channel_config
  import chan_cfg_pkg::*;
#(
  parameter logic [15:0] CONV_CYCLES      = 16'(`CONV_CYCLES),
  parameter logic [15:0] DIODE_SUB_CYCLES = 16'(`DIODE_SUB_CYCLES)
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Register access
  input  wire logic       mode_wr,
  input  wire logic [7:0] mode_wdata,
  output logic [7:0]      mode_rdata,
  input  wire logic       start_en,
  input  wire logic [1:0] cfg2_alert_en,
  // Voltage-code pins
  input  wire logic [4:0] core_volt_pin,
  output logic [4:0]      core_volt_code,
  output logic [4:0]      ext_alert_in,
  // Pin functions
  output logic            tach_input_a,
  output logic            tach_input_b,
  output logic            second_diode_en,
  output logic            range_5v,
  // Converter
  output logic            conv_start,
  output logic [3:0]      mux_sel,
  output logic            atten_en,
  input  wire logic       conv_done,
  input  wire logic [7:0] conv_data,
  // Results
  output logic            result_wr,
  output logic [3:0]      result_chan,
  output logic [7:0]      result_data
);

  // ----------------------------------------
  // Mode register and pin functions
  // ----------------------------------------
  logic [7:0] mode_reg, mode_next;
  logic [4:0] pin_s1_reg, pin_s2_reg;
  logic [4:0] code_reg, code_next;
  logic [4:0] alert_reg, alert_next;
  logic [4:0] alert_en;
  logic [3:0] pinfn_reg, pinfn_next;

  always_comb begin
    mode_next = mode_reg;
    if (mode_wr) begin
      mode_next = mode_wdata;
    end
    alert_en = {cfg2_alert_en[1], cfg2_alert_en[0],                 // see [RQ6]
                mode_reg[`MODE_ALERT2_BIT], mode_reg[`MODE_ALERT1_BIT],
                mode_reg[`MODE_ALERT0_BIT]};                          // see [RQ5]
    if (mode_reg[`MODE_ALERTS_BIT]) begin                             // see [RQ4]
      code_next  = 5'h00;
      alert_next = pin_s2_reg & alert_en;
    end else begin
      code_next  = pin_s2_reg;
      alert_next = 5'h00;
    end
    pinfn_next = {mode_reg[`MODE_RANGE5_BIT],                          // see [RQ3]
                  mode_reg[`MODE_DIODE2_BIT],                          // see [RQ2]
                  !mode_reg[`MODE_AUXB_BIT], !mode_reg[`MODE_AUXA_BIT]}; // see [RQ1]
  end

  // Pins cross from outside, so two stages before use
  always_ff @(posedge sys_clk) begin
    pin_s1_reg <= core_volt_pin;
    pin_s2_reg <= pin_s1_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_reg  <= `MODE_RESET;                                        // see [RQ7]
      code_reg  <= 5'h00;
      alert_reg <= 5'h00;
      pinfn_reg <= 4'h0;
    end else begin
      mode_reg  <= mode_next;
      code_reg  <= code_next;
      alert_reg <= alert_next;
      pinfn_reg <= pinfn_next;
    end
  end

  assign mode_rdata      = mode_reg;
  assign core_volt_code  = code_reg;
  assign ext_alert_in    = alert_reg;
  assign tach_input_a    = pinfn_reg[0];
  assign tach_input_b    = pinfn_reg[1];
  assign second_diode_en = pinfn_reg[2];
  assign range_5v        = pinfn_reg[3];

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  seq_state_t  state_reg, state_next;
  chan_t       chan_reg, chan_next;
  logic [3:0]  sub_reg, sub_next;
  logic [7:0]  sample_reg, sample_next;
  logic        cstart_reg, cstart_next;
  logic [3:0]  msel_reg, msel_next;
  logic        atten_reg, atten_next;
  logic        rwr_reg, rwr_next;
  logic [3:0]  rchan_reg, rchan_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        restart, tick, avg_clr, avg_add;
  logic        chan_on, is_diode;
  logic [7:0]  avg;
  logic [15:0] slot_len;

  // Dedicated channels always on; shared pins follow the mode bits
  always_comb begin
    case (chan_reg)
      CH_AUXA:   chan_on = mode_reg[`MODE_AUXA_BIT];                   // see [RQ16]
      CH_AUXB:   chan_on = mode_reg[`MODE_AUXB_BIT];                   // see [RQ16]
      CH_2V5:    chan_on = !mode_reg[`MODE_DIODE2_BIT];                // see [RQ2]
      CH_CORE_B: chan_on = !mode_reg[`MODE_DIODE2_BIT];                // see [RQ2]
      CH_DIODE2: chan_on = mode_reg[`MODE_DIODE2_BIT];                 // see [RQ16]
      default:   chan_on = 1'b1;                                       // see [RQ8]
    endcase
    is_diode = (chan_reg == CH_DIODE1) || (chan_reg == CH_DIODE2);
    slot_len = is_diode ? DIODE_SUB_CYCLES : CONV_CYCLES;              // see [RQ11]
  end

  always_comb begin
    state_next  = state_reg;
    chan_next   = chan_reg;
    sub_next    = sub_reg;
    sample_next = conv_done ? conv_data : sample_reg;                  // see [RQ9]
    cstart_next = 1'b0;
    msel_next   = msel_reg;
    atten_next  = atten_reg;
    rwr_next    = 1'b0;
    rchan_next  = rchan_reg;
    rdata_next  = rdata_reg;
    restart     = 1'b0;
    avg_clr     = 1'b0;
    avg_add     = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_en) begin
          chan_next  = CH_DIODE1;
          state_next = ST_SELECT;
        end
      end
      ST_SELECT: begin
        if (!start_en) begin
          state_next = ST_IDLE;                                        // see [RQ14]
        end else if (chan_on) begin
          cstart_next = 1'b1;
          msel_next   = chan_reg;
          // Rails other than aux and diodes go through an attenuator
          atten_next  = !is_diode && chan_reg != CH_AUXA
                        && chan_reg != CH_AUXB;                        // see [RQ10]
          restart     = 1'b1;
          avg_clr     = 1'b1;
          sub_next    = 4'h0;
          state_next  = ST_CONVERT;
        end else begin
          chan_next = (chan_reg == CH_DIODE2) ? CH_DIODE1
                                              : chan_t'(chan_reg + 4'h1); // see [RQ16]
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          if (is_diode) begin
            avg_add = 1'b1;                                            // see [RQ12]
            if (sub_reg == 4'(`DIODE_AVG_COUNT - 1)) begin
              state_next = ST_STORE;
            end else begin
              sub_next    = sub_reg + 4'h1;
              cstart_next = 1'b1;
              restart     = 1'b1;
            end
          end else begin
            state_next = ST_STORE;
          end
        end
      end
      ST_STORE: begin
        rwr_next   = 1'b1;                                             // see [RQ13]
        rchan_next = chan_reg;
        rdata_next = is_diode ? avg : sample_reg;                      // see [RQ15]
        chan_next  = (chan_reg == CH_DIODE2) ? CH_DIODE1
                                             : chan_t'(chan_reg + 4'h1);
        // Start bit is checked again at the next channel
        state_next = ST_SELECT;                                        // see [RQ14]
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg  <= ST_IDLE;
      chan_reg   <= CH_DIODE1;
      sub_reg    <= 4'h0;
      sample_reg <= 8'h00;
      cstart_reg <= 1'b0;
      msel_reg   <= 4'h0;
      atten_reg  <= 1'b0;
      rwr_reg    <= 1'b0;
      rchan_reg  <= 4'h0;
      rdata_reg  <= 8'h00;
    end else begin
      state_reg  <= state_next;
      chan_reg   <= chan_next;
      sub_reg    <= sub_next;
      sample_reg <= sample_next;
      cstart_reg <= cstart_next;
      msel_reg   <= msel_next;
      atten_reg  <= atten_next;
      rwr_reg    <= rwr_next;
      rchan_reg  <= rchan_next;
      rdata_reg  <= rdata_next;
    end
  end

  period_tick #(.W(16)) u_slot (
    .sys_clk (sys_clk),
    .srst    (srst),
    .restart (restart),
    .period  (slot_len),
    .tick    (tick)
  );

  diode_avg #(.LOG2N(4)) u_avg (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clr     (avg_clr),
    .add     (avg_add),
    .sample  (sample_reg),
    .avg     (avg)
  );

  assign conv_start  = cstart_reg;
  assign mux_sel     = msel_reg;
  assign atten_en    = atten_reg;
  assign result_wr   = rwr_reg;
  assign result_chan = rchan_reg;
  assign result_data = rdata_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [15:0] slot_cnt_reg;
  logic [4:0]  starts_reg;
  logic [2:0]  rst_hist_reg;

  always_ff @(posedge sys_clk) begin
    slot_cnt_reg <= cstart_reg ? 16'h0001 : slot_cnt_reg + 16'h0001;
    rst_hist_reg <= {rst_hist_reg[1:0], srst};
    if (srst || rwr_reg) begin
      starts_reg <= 5'h00;
    end else if (cstart_reg) begin
      starts_reg <= starts_reg + 5'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_mode_reset: assert property (disable iff (1'b0) srst |=> mode_reg == 8'h00) // see [RQ7]
    else $error("mode register not cleared by reset");
  a_tach_skip: assert property (state_reg == ST_SELECT && start_en && !chan_on // see [RQ16]
    |=> !cstart_reg) else $error("conversion started on tach pin");
  a_fixed_chan: assert property (state_reg == ST_SELECT && start_en // see [RQ8]
    && chan_reg inside {CH_DIODE1, CH_12V, CH_5V, CH_CORE_A, CH_VCC}
    |=> cstart_reg && msel_reg == $past(chan_reg)) else $error("dedicated channel skipped");
  a_range_follow: assert property (mode_wr |-> ##2 range_5v == $past(mode_wdata[3], 2)) // see [RQ3]
    else $error("range select does not follow mode bit 3");
  a_code_pass: assert property (rst_hist_reg == 3'b000 && !$past(mode_reg[7]) // see [RQ4]
    |-> core_volt_code == $past(core_volt_pin, 3)) else $error("voltage code not passed");
  a_alert_gate: assert property (|ext_alert_in |-> $past(mode_reg[7])) // see [RQ4]
    else $error("alert while in code mode");
  a_alert_en0: assert property (ext_alert_in[0] |-> $past(mode_reg[4])) // see [RQ5]
    else $error("alert 0 not enabled");
  a_alert_en3: assert property (ext_alert_in[3] |-> $past(cfg2_alert_en[0])) // see [RQ6]
    else $error("alert 3 not enabled");
  a_slot_time: assert property (rwr_reg |-> slot_cnt_reg == // see [RQ11]
    ((rchan_reg == CH_DIODE1 || rchan_reg == CH_DIODE2) ? DIODE_SUB_CYCLES : CONV_CYCLES)
    + 16'h0001) else $error("conversion slot length wrong");
  a_diode_count: assert property (rwr_reg && (rchan_reg == CH_DIODE1 // see [RQ12]
    || rchan_reg == CH_DIODE2) |-> starts_reg == 5'h10) else $error("diode not averaged 16x");
  a_store_chan: assert property (state_reg == ST_STORE |=> rwr_reg // see [RQ13]
    && rchan_reg == $past(chan_reg)) else $error("result not stored");
  a_stop_idle: assert property (state_reg == ST_IDLE && !start_en |=> !cstart_reg) // see [RQ14]
    else $error("converter runs while stopped");

  c_diode2: cover property (rwr_reg && rchan_reg == CH_DIODE2);
  c_auxa: cover property (rwr_reg && rchan_reg == CH_AUXA);
  c_alert: cover property (|ext_alert_in);
  c_stop: cover property (state_reg == ST_SELECT && !start_en);

endmodule : measurement_channel_config
`default_nettype wire

// ### verification/sar_adc_model.sv
// Behavioural converter standing in for the SAR, mux and monitored inputs.
// Assumes conv_start and mux_sel are registered on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_model (
  // Clock
  input  wire logic       sys_clk,
  // Converter side
  input  wire logic       conv_start,
  input  wire logic [3:0] mux_sel,
  output logic            conv_done,
  output logic [7:0]      conv_data
);
  int         wait_n;
  logic [3:0] chan;
  logic       flip;

  initial begin
    conv_done = 1'b0;
    conv_data = 8'h00;
    wait_n    = 0;
    chan      = 4'h0;
    flip      = 1'b0;
  end

  // ----------------------------------------
  // Answer
  // ----------------------------------------
  // Odd channels answer slowly; data is never held outside the done pulse
  always @(negedge sys_clk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (conv_start === 1'b1) begin
      wait_n <= mux_sel[0] ? 5 : 1;
      chan   <= mux_sel;
    end else if (wait_n > 0) begin
      wait_n <= wait_n - 1;
      if (wait_n == 1) begin
        conv_done <= 1'b1;
        if (chan == 4'h0 || chan == 4'h9) begin
          conv_data <= flip ? 8'hfe : 8'hfd;
          flip      <= ~flip;
        end else begin
          conv_data <= 8'h40 + 8'(chan);
        end
      end
    end
  end
endmodule : sar_adc_model
`default_nettype wire

// ### verification/measurement_channel_config_bench.sv
// Self-checking bench for the channel mode register and conversion sequencer.
// Assumes sar_adc_model as converter; short slot counts keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module measurement_channel_config_bench;
  import chan_cfg_pkg::*;

  localparam logic [15:0] P_ORD = 16'h0014;
  localparam logic [15:0] P_DIO = 16'h0008;
  // Expected round-robin orders, first channel in the low nibble
  localparam logic [31:0] SEQ_A = 32'h0874_3210;
  localparam logic [31:0] SEQ_B = 32'h0965_4321;

  logic       sys_clk, srst, mode_wr, start_en, conv_start, conv_done;
  logic       result_wr, atten_en, tach_input_a, tach_input_b, second_diode_en, range_5v;
  logic [7:0] mode_wdata, mode_rdata, conv_data, result_data;
  logic [1:0] cfg2_alert_en;
  logic [4:0] core_volt_pin, core_volt_code, ext_alert_in;
  logic [3:0] mux_sel, result_chan, msel_seen;
  logic       atten_seen;
  int         mismatches, tests_run, cnt, nstarts;

  measurement_channel_config #(.CONV_CYCLES(P_ORD), .DIODE_SUB_CYCLES(P_DIO))
    measurement_channel_config_i (
    .sys_clk(sys_clk), .srst(srst), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
    .mode_rdata(mode_rdata), .start_en(start_en), .cfg2_alert_en(cfg2_alert_en),
    .core_volt_pin(core_volt_pin), .core_volt_code(core_volt_code),
    .ext_alert_in(ext_alert_in), .tach_input_a(tach_input_a), .tach_input_b(tach_input_b),
    .second_diode_en(second_diode_en), .range_5v(range_5v), .conv_start(conv_start),
    .mux_sel(mux_sel), .atten_en(atten_en), .conv_done(conv_done), .conv_data(conv_data),
    .result_wr(result_wr), .result_chan(result_chan), .result_data(result_data));

  sar_adc_model sar_adc_model_i (
    .sys_clk(sys_clk), .conv_start(conv_start), .mux_sel(mux_sel),
    .conv_done(conv_done), .conv_data(conv_data));

  // ----------------------------------------
  // Clock and slot monitor
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Readers at the same edge see the value before this update
  always @(negedge sys_clk) begin
    if (conv_start === 1'b1) begin
      cnt        <= 0;
      nstarts    <= nstarts + 1;
      atten_seen <= atten_en;
      msel_seen  <= mux_sel;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic write_mode(input logic [7:0] v);
    mode_wr    = 1'b1;
    mode_wdata = v;
    tick(1);
    mode_wr = 1'b0;
    tick(2);
  endtask : write_mode

  task automatic expect_result(input logic [3:0] ch);
    int   n;
    logic dio;
    n   = 0;
    dio = (ch == 4'h0 || ch == 4'h9);
    tick(1);
    while (result_wr !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    check("result_wr", 16'(result_wr), 16'h0001);
    check("result_chan", 16'(result_chan), 16'(ch));
    check("result_data", 16'(result_data),
          dio ? 16'h00fd : 16'(8'h40 + 8'(ch)));
    check("slot_cycles", 16'(cnt), dio ? P_DIO : P_ORD);
    check("conv_count", 16'(nstarts), dio ? 16'h0010 : 16'h0001);
    check("atten_en", 16'(atten_seen), 16'(!dio && ch != 4'h5 && ch != 4'h6));
    check("mux_sel", 16'(msel_seen), 16'(ch));
    nstarts = 0;
  endtask : expect_result

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [7:0] v;
    logic [4:0] en;
    srst = 1'b1; mode_wr = 1'b0; mode_wdata = 8'h00; start_en = 1'b0;
    cfg2_alert_en = 2'b00; core_volt_pin = 5'h15;
    mismatches = 0; tests_run = 0; cnt = 0; nstarts = 0;
    tick(3);
    srst = 1'b0;
    tick(2);
    check("mode_reset", 16'(mode_rdata), 16'h0000);
    check("pins_reset", 16'({tach_input_a, tach_input_b, second_diode_en, range_5v}),
          16'h000c);
    // Each function bit alone, then all of them
    for (int i = 0; i <= 4; i++) begin
      v = (i == 4) ? 8'h0f : 8'(1 << i);
      write_mode(v);
      check("mode_rdata", 16'(mode_rdata), 16'(v));
      check("pin_funcs", 16'({tach_input_a, tach_input_b, second_diode_en, range_5v}),
            16'({~v[0], ~v[1], v[2], v[3]}));
    end
    // Code pins against alert enables
    for (int i = 0; i < 8; i++) begin
      v = {i[0], i[1] ? 3'b011 : 3'b100, 4'h0};
      cfg2_alert_en = i[2:1];
      core_volt_pin = i[0] ? 5'h1f : 5'h0e;
      write_mode(v);
      tick(4);
      en = {cfg2_alert_en, v[6:4]};
      check("volt_code", 16'(core_volt_code), v[7] ? 16'h0000 : 16'(core_volt_pin));
      check("alerts", 16'(ext_alert_in),
            v[7] ? 16'(core_volt_pin & en) : 16'h0000);
    end
    // Tach pins and rail pair first; then analog pins and second diode
    write_mode(8'h00);
    nstarts  = 0;
    start_en = 1'b1;
    for (int k = 0; k < 8; k++) expect_result(SEQ_A[4*k +: 4]);
    write_mode(8'h07);
    for (int k = 0; k < 8; k++) expect_result(SEQ_B[4*k +: 4]);
    // Stop while channel 1 converts: it completes, then all stays quiet
    for (int n = 0; n < 100 && conv_start !== 1'b1; n++) tick(1);
    start_en = 1'b0;
    expect_result(4'h1);
    tick(200);
    check("stopped", 16'(nstarts), 16'h0000);
    tally_and_finish();
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(negedge sys_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : measurement_channel_config_bench
`default_nettype wire
